// >>> src/fpt_channel.sv
`timescale 1ns/100ps
module fpt_channel
   import fpt_pkg::*;
#(
   parameter int CW      = fpt_pkg::FPT_COUNT_W,
   parameter bit HAS_CMP = 1'b1
)
(
   // clock and reset
   input  wire logic          clk_sys,
   input  wire logic          reset,
   // control
   input  wire logic          tick,
   input  wire logic          run,
   input  wire logic          auto_reload,
   input  wire logic          load,
   input  wire logic [CW-1:0] cnt_buf,
   input  wire logic [CW-1:0] cmp_buf,
   // state
   output logic      [CW-1:0] count,
   output logic               pulse,
   output logic               zero_evt
);
   logic [CW-1:0] count_q;
   logic [CW-1:0] cmp_q;
   logic          zero_evt_q;

   // the live compare only changes on a load or an auto reload at zero, so the buffer may be rewritten between them
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         count_q <= '0;
         cmp_q   <= '0;
      end
      else if (load)
      begin
         count_q <= cnt_buf;
         cmp_q   <= HAS_CMP ? cmp_buf : '0;
      end
      else if (tick && run)
      begin
         if (count_q != '0)
            count_q <= count_q - 1'b1;
         else if (auto_reload)
         begin
            count_q <= cnt_buf;
            cmp_q   <= HAS_CMP ? cmp_buf : '0;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         zero_evt_q <= 1'b0;
      else
         zero_evt_q <= !load && tick && run && (count_q == CW'(1));
   end

   // output low above the compare value, high from the match down to zero
   assign pulse    = (count_q <= cmp_q);
   assign count    = count_q;
   assign zero_evt = zero_evt_q;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   manual_load_a: assert property (load |=> count == $past(cnt_buf))
      else $error("manual load did not copy the count buffer");
   run_halt_a: assert property (!run && !load |=> $stable(count))
      else $error("halted counter moved");
   auto_reload_a: assert property (
      tick && run && !load && count == '0 && auto_reload |=> count == $past(cnt_buf))
      else $error("auto reload missing");
   one_shot_a: assert property (
      tick && run && !load && count == '0 && !auto_reload |=> count == '0)
      else $error("one shot counter left zero");
endmodule

// >>> src/fpt_pkg.sv
package fpt_pkg;
   // channel structure
   localparam int          FPT_CHANNELS   = 5;
   localparam int          FPT_CMP_CHANS  = 4;
   localparam int          FPT_COUNT_W    = 16;
   localparam int          FPT_DIV_W      = 4;
   localparam int          FPT_PRE_W      = 8;
   localparam int          FPT_PIN_CHANS  = 4;
   // register byte addresses
   localparam logic [31:0] FPT_PRESCALE_ADDR = 32'h44000000;
   localparam logic [31:0] FPT_DIVDMA_ADDR   = 32'h44000004;
   localparam logic [31:0] FPT_CONTROL_ADDR  = 32'h44000008;
   localparam logic [31:0] FPT_CNTB_ADDR [FPT_CHANNELS] =
      '{32'h4400000C, 32'h44000018, 32'h44000024, 32'h44000030, 32'h4400003C};
   localparam logic [31:0] FPT_CMPB_ADDR [FPT_CMP_CHANS] =
      '{32'h44000010, 32'h4400001C, 32'h44000028, 32'h44000034};
   localparam logic [31:0] FPT_OBS_ADDR [FPT_CHANNELS] =
      '{32'h44000014, 32'h44000020, 32'h4400002C, 32'h44000038, 32'h44000040};
   localparam logic [31:0] FPT_STATUS_ADDR   = 32'h44000048;
   localparam logic [31:0] FPT_MASK_ADDR     = 32'h4400004C;
   // reset values and writable bits
   localparam logic [31:0] FPT_RESET_VAL     = 32'h00000000;
   localparam logic [31:0] FPT_PRESCALE_MASK = 32'h00FFFFFF;
   localparam logic [31:0] FPT_DIVDMA_MASK   = 32'h00FFFFFF;
   localparam logic [31:0] FPT_CONTROL_MASK  = 32'h007FFF1F;
   // field positions
   localparam int          FPT_PRE0_LSB      = 0;
   localparam int          FPT_PRE1_LSB      = 8;
   localparam int          FPT_DZLEN_LSB     = 16;
   localparam int          FPT_DMA_LSB       = 20;
   localparam int          FPT_DEADZONE_BIT  = 4;
   localparam int          FPT_RUN_POS    [FPT_CHANNELS] = '{0, 8, 12, 16, 20};
   localparam int          FPT_UPDATE_POS [FPT_CHANNELS] = '{1, 9, 13, 17, 21};
   localparam int          FPT_INVERT_POS [FPT_PIN_CHANS] = '{2, 10, 14, 18};
   localparam int          FPT_RELOAD_POS [FPT_CHANNELS] = '{3, 11, 15, 19, 22};
   // divider codes and dma selector
   localparam logic [3:0]  FPT_DIV_MAX_CODE  = 4'h3;
   localparam logic [3:0]  FPT_DIV_SAT_LIM   = 4'hF;
   localparam logic [3:0]  FPT_DMA_NONE      = 4'h0;
   localparam int          FPT_PRE_CHANS0    = 2;

   typedef logic [31:0] fpt_word_t;
endpackage

// >>> src/fpt_timer.sv
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
module fpt_timer
   import fpt_pkg::*;
#(
   parameter int NCH = fpt_pkg::FPT_CHANNELS,
   parameter int CW  = fpt_pkg::FPT_COUNT_W
)
(
   // clock and reset
   input  wire logic          clk_sys,
   input  wire logic          reset,
   // register port
   input  wire fpt_pkg::fpt_word_t reg_addr,
   input  wire fpt_pkg::fpt_word_t reg_wdata,
   input  wire logic          reg_write,
   input  wire logic          reg_read,
   output fpt_pkg::fpt_word_t reg_rdata,
   // dma and interrupt
   input  wire logic          dma_ack,
   output logic               dma_request_n,
   output logic               irq,
   // pins
   output logic [fpt_pkg::FPT_PIN_CHANS-1:0] pulse_output
);
   import fpt_pkg::*;

   if (NCH != FPT_CHANNELS || CW < 1 || CW > 32)
      $error("fpt_timer: channel map is fixed at five and counter width is 1..32");

   fpt_word_t        prescale_q;
   fpt_word_t        divdma_q;
   fpt_word_t        control_q;
   logic [CW-1:0]    cntb_q [NCH];
   logic [CW-1:0]    cmpb_q [FPT_CMP_CHANS];
   logic [NCH-1:0]   status_q;
   logic [NCH-1:0]   mask_q;
   logic             irq_q;
   logic             dma_req_n_q;
   fpt_word_t        rdata_q;
   logic [FPT_PIN_CHANS-1:0] pin_q;
   logic [FPT_PRE_W-1:0] pre_cnt_q [2];
   logic [1:0]       pre_tick;
   logic [NCH-1:0]   tick;
   logic [NCH-1:0]   pulse;
   logic [NCH-1:0]   zero_evt;
   logic [NCH-1:0]   load;
   logic [NCH-1:0]   dma_oh;
   logic [CW-1:0]    count [NCH];
   logic [FPT_PRE_W-1:0] dz_cnt_q;
   logic             dz_prev_q;
   logic             dz_done;
   logic             src0;
   fpt_word_t        rdata_d;
   logic [NCH-1:0]   status_d;
   logic [3:0]       dma_code;
   logic             dma_evt;

   assign dma_code = divdma_q[FPT_DMA_LSB +: 4];

   // register writes; reserved bits never store
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         prescale_q <= FPT_RESET_VAL;
         divdma_q   <= FPT_RESET_VAL;
         control_q  <= FPT_RESET_VAL;
         mask_q     <= '0;
      end
      else if (reg_write)
      begin
         if (reg_addr == FPT_PRESCALE_ADDR)
            prescale_q <= reg_wdata & FPT_PRESCALE_MASK;
         if (reg_addr == FPT_DIVDMA_ADDR)
            divdma_q <= reg_wdata & FPT_DIVDMA_MASK;
         if (reg_addr == FPT_CONTROL_ADDR)
            control_q <= reg_wdata & FPT_CONTROL_MASK;
         if (reg_addr == FPT_MASK_ADDR)
            mask_q <= reg_wdata[NCH-1:0];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         for (int i = 0; i < NCH; i++)
            cntb_q[i] <= '0;
         for (int i = 0; i < FPT_CMP_CHANS; i++)
            cmpb_q[i] <= '0;
      end
      else if (reg_write)
      begin
         for (int i = 0; i < NCH; i++)
            if (reg_addr == FPT_CNTB_ADDR[i])
               cntb_q[i] <= reg_wdata[CW-1:0];
         for (int i = 0; i < FPT_CMP_CHANS; i++)
            if (reg_addr == FPT_CMPB_ADDR[i])
               cmpb_q[i] <= reg_wdata[CW-1:0];
      end
   end

   // the load fires on the write itself; a bit left set is not replayed, only keeps
   // the readback honest
   always_comb
   begin
      for (int i = 0; i < NCH; i++)
         load[i] = reg_write && (reg_addr == FPT_CONTROL_ADDR)
                   && reg_wdata[FPT_UPDATE_POS[i]];
   end

   // two shared prescalers
   always_ff @(posedge clk_sys)
   begin
      for (int p = 0; p < 2; p++)
      begin
         if (reset || pre_tick[p])
            pre_cnt_q[p] <= '0;
         else
            pre_cnt_q[p] <= pre_cnt_q[p] + 1'b1;
      end
   end

   // compare as at-or-above so lowering a prescaler never waits for a full 8-bit wrap
   assign pre_tick[0] = (pre_cnt_q[0] >= prescale_q[FPT_PRE0_LSB +: FPT_PRE_W]);
   assign pre_tick[1] = (pre_cnt_q[1] >= prescale_q[FPT_PRE1_LSB +: FPT_PRE_W]);

   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      localparam int GRP = (c < FPT_PRE_CHANS0) ? 0 : 1;
      logic [FPT_DIV_W-1:0] sel;
      logic [FPT_DIV_W-1:0] lim;
      logic [FPT_DIV_W-1:0] div_cnt_q;
      logic                 tick_q;

      assign sel = divdma_q[FPT_DIV_W*c +: FPT_DIV_W];
      // undefined divider codes saturate at the slowest rate
      assign lim = (sel > FPT_DIV_MAX_CODE) ? FPT_DIV_SAT_LIM
                                            : FPT_DIV_W'((2 << sel) - 1);

      always_ff @(posedge clk_sys)
      begin
         if (reset)
         begin
            div_cnt_q <= '0;
            tick_q    <= 1'b0;
         end
         else
         begin
            tick_q <= pre_tick[GRP] && (div_cnt_q >= lim);
            if (pre_tick[GRP])
               div_cnt_q <= (div_cnt_q >= lim) ? '0 : div_cnt_q + 1'b1;
         end
      end

      assign tick[c] = tick_q;

      fpt_channel #(
         .CW      (CW),
         .HAS_CMP (c < FPT_CMP_CHANS)
      ) u_chan (
         .clk_sys     (clk_sys),
         .reset       (reset),
         .tick        (tick[c]),
         .run         (control_q[FPT_RUN_POS[c]]),
         .auto_reload (control_q[FPT_RELOAD_POS[c]]),
         .load        (load[c]),
         .cnt_buf     (cntb_q[c]),
         .cmp_buf     ((c < FPT_CMP_CHANS) ? cmpb_q[c % FPT_CMP_CHANS] : '0),
         .count       (count[c]),
         .pulse       (pulse[c]),
         .zero_evt    (zero_evt[c])
      );

      assign dma_oh[c] = (dma_code == 4'(c + 1));

      tick_source_a: assert property (@(posedge clk_sys) disable iff (reset)
         tick[c] |-> $past(pre_tick[GRP]))
         else $error("channel tick without prescaler tick");
      irq_set_a: assert property (@(posedge clk_sys) disable iff (reset)
         zero_evt[c] && !dma_oh[c] |=> status_q[c])
         else $error("zero event did not set status");
      dma_no_int_a: assert property (@(posedge clk_sys) disable iff (reset)
         zero_evt[c] && dma_oh[c] && !status_q[c] |=> !status_q[c])
         else $error("dma channel raised an interrupt");
      obs_read_a: assert property (@(posedge clk_sys) disable iff (reset)
         reg_read && reg_addr == FPT_OBS_ADDR[c]
         |=> reg_rdata == fpt_word_t'($past(count[c])))
         else $error("observation read wrong");
   end

   // sticky status, set wins over write-one-clear; dma channel is excluded
   always_comb
   begin
      status_d = status_q;
      if (reg_write && reg_addr == FPT_STATUS_ADDR)
         status_d = status_q & ~reg_wdata[NCH-1:0];
      status_d = status_d | (zero_evt & ~dma_oh);
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         status_q <= '0;
         irq_q    <= 1'b0;
      end
      else
      begin
         status_q <= status_d;
         irq_q    <= |(status_q & mask_q);
      end
   end

   // request stays low until acknowledged; a fresh event wins over the ack
   assign dma_evt = |(zero_evt & dma_oh);
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         dma_req_n_q <= 1'b1;
      else if (dma_evt)
         dma_req_n_q <= 1'b0;
      else if (dma_ack)
         dma_req_n_q <= 1'b1;
   end

   // dead zone: both pin0 and pin1 stay low for the programmed number of channel 0 ticks
   // after each edge of the channel 0 pulse, so the pair never overlaps
   assign src0    = pulse[0] ^ control_q[FPT_INVERT_POS[0]];
   assign dz_done = (dz_cnt_q >= prescale_q[FPT_DZLEN_LSB +: FPT_PRE_W]);

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         dz_cnt_q  <= '0;
         dz_prev_q <= 1'b0;
      end
      else
      begin
         dz_prev_q <= src0;
         if (src0 != dz_prev_q)
            dz_cnt_q <= '0;
         else if (tick[0] && !dz_done)
            dz_cnt_q <= dz_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         pin_q <= '0;
      else
      begin
         for (int i = 0; i < FPT_PIN_CHANS; i++)
            pin_q[i] <= pulse[i] ^ control_q[FPT_INVERT_POS[i]];
         if (control_q[FPT_DEADZONE_BIT])
         begin
            pin_q[0] <= src0 && dz_done && (src0 == dz_prev_q);
            pin_q[1] <= !src0 && dz_done && (src0 == dz_prev_q);
         end
      end
   end

   // read data in the cycle after the strobe only; unmapped reads return zero
   always_comb
   begin
      rdata_d = '0;
      if (reg_addr == FPT_PRESCALE_ADDR)
         rdata_d = prescale_q;
      if (reg_addr == FPT_DIVDMA_ADDR)
         rdata_d = divdma_q;
      if (reg_addr == FPT_CONTROL_ADDR)
         rdata_d = control_q;
      if (reg_addr == FPT_STATUS_ADDR)
         rdata_d = fpt_word_t'(status_q);
      if (reg_addr == FPT_MASK_ADDR)
         rdata_d = fpt_word_t'(mask_q);
      for (int i = 0; i < NCH; i++)
      begin
         if (reg_addr == FPT_CNTB_ADDR[i])
            rdata_d = fpt_word_t'(cntb_q[i]);
         if (reg_addr == FPT_OBS_ADDR[i])
            rdata_d = fpt_word_t'(count[i]);
      end
      for (int i = 0; i < FPT_CMP_CHANS; i++)
         if (reg_addr == FPT_CMPB_ADDR[i])
            rdata_d = fpt_word_t'(cmpb_q[i]);
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset || !reg_read)
         rdata_q <= '0;
      else
         rdata_q <= rdata_d;
   end

   assign reg_rdata     = rdata_q;
   assign dma_request_n = dma_req_n_q;
   assign irq           = irq_q;
   assign pulse_output  = pin_q;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   dma_hold_a: assert property (!dma_request_n && !dma_ack |=> !dma_request_n)
      else $error("dma request dropped before ack");
   dma_release_a: assert property (
      !dma_request_n && dma_ack && !dma_evt |=> dma_request_n)
      else $error("dma request not released after ack");
   irq_level_a: assert property (|(status_q & mask_q) |=> irq)
      else $error("interrupt not raised for unmasked status");
   reserved_zero_a: assert property (
      (control_q & ~FPT_CONTROL_MASK) == '0 && (divdma_q & ~FPT_DIVDMA_MASK) == '0)
      else $error("reserved bits stored");
   cntb_read_a: assert property (
      reg_write && reg_addr == FPT_CNTB_ADDR[0] ##1 reg_read && reg_addr == FPT_CNTB_ADDR[0]
      |=> reg_rdata == ($past(reg_wdata, 2) & 32'h0000FFFF))
      else $error("count buffer readback wrong");
   pin_invert_a: assert property (
      !$past(reset) |-> pulse_output[2] == $past(pulse[2] ^ control_q[FPT_INVERT_POS[2]]))
      else $error("inverted pin wrong");
   deadzone_a: assert property (control_q[FPT_DEADZONE_BIT] ##1 control_q[FPT_DEADZONE_BIT]
      |-> !(pulse_output[0] && pulse_output[1]))
      else $error("dead zone pair overlaps");
   read_once_a: assert property (!reg_read |=> reg_rdata == '0)
      else $error("read data outside its cycle");
endmodule

// >>> verification/five_channel_pwm_timer_control_tb.sv
`timescale 1ns/100ps
module five_channel_pwm_timer_control_tb;
   import fpt_pkg::*;
   logic       clk_sys   = 1'b0;
   logic       reset     = 1'b1;
   fpt_word_t  reg_addr  = 32'h00000000;
   fpt_word_t  reg_wdata = 32'h00000000;
   logic       reg_write = 1'b0;
   logic       reg_read  = 1'b0;
   fpt_word_t  reg_rdata;
   logic       dma_ack;
   logic       dma_request_n;
   logic       irq;
   logic [3:0] pulse_output;
   logic [3:0] ack_delay = 4'h0;
   int         n_mismatch  = 0;
   int         check_count = 0;
   fpt_word_t  va;
   fpt_word_t  vb;

   always #50 clk_sys = ~clk_sys;

   fpt_timer i_fpt_timer (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .dma_ack(dma_ack), .dma_request_n(dma_request_n),
      .irq(irq), .pulse_output(pulse_output));

   fpt_dma_model i_fpt_dma_model (.clk_sys(clk_sys), .reset(reset),
      .dma_request_n(dma_request_n), .dma_ack(dma_ack), .ack_delay(ack_delay));

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wr(input fpt_word_t a, input fpt_word_t d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe, so sample just after that edge
   task automatic rd(input fpt_word_t a, output fpt_word_t d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // write then read back with no gap, as the port allows
   task automatic wr_rd(input fpt_word_t a, input fpt_word_t d, output fpt_word_t q);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      reg_read  <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1;
      q = reg_rdata;
   endtask

   task automatic chk_word(input string n, input fpt_word_t e, input fpt_word_t g);
      check_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_bit(input string n, input logic e, input logic g);
      check_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("Error %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic chk_reg(input string n, input fpt_word_t a, input fpt_word_t e);
      fpt_word_t v;
      rd(a, v);
      chk_word(n, e, v);
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask

   task automatic wait_stat(input int b);
      fpt_word_t v;
      v = 32'h00000000;
      for (int i = 0; i < 200 && v[b] !== 1'b1; i++)
         rd(FPT_STATUS_ADDR, v);
      chk_bit("status event", 1'b1, v[b]);
   endtask

   // one-shot start of channel 0; the request must stay low until the model acknowledges
   task automatic dma_round(input logic [3:0] d);
      logic seen;
      int   n;
      seen = 1'b0;
      n    = 0;
      ack_delay <= d;
      wr(FPT_CNTB_ADDR[0], 32'h00000002);
      wr(FPT_CONTROL_ADDR, 32'h00000002);
      wr(FPT_CONTROL_ADDR, 32'h00000001);
      while (dma_request_n !== 1'b0 && n < 100)
      begin
         settle(1);
         n++;
      end
      chk_bit("dma request", 1'b0, dma_request_n);
      while (dma_request_n !== 1'b1 && n < 200)
      begin
         seen = seen | (dma_ack === 1'b1);
         chk_bit("irq during dma", 1'b0, irq);
         settle(1);
         n++;
      end
      chk_bit("request held until ack", 1'b1, seen);
      chk_bit("request released", 1'b1, dma_request_n);
   endtask

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      $display("Error watchdog expired");
      close_out();
   end

   initial
   begin
      fpt_word_t ra [7];
      ra = '{FPT_DIVDMA_ADDR, FPT_CONTROL_ADDR, FPT_CNTB_ADDR[0], FPT_CMPB_ADDR[0],
             FPT_OBS_ADDR[0], FPT_CNTB_ADDR[1], FPT_CMPB_ADDR[1]};
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      foreach (ra[i])
         chk_reg("reset value", ra[i], 32'h00000000);
      chk_word("pins after reset", 32'h0000000F, {28'h0000000, pulse_output});
      // buffers keep 16 bits; upper half of the word is reserved
      for (int i = 2; i < 7; i++)
      begin
         wr_rd(ra[i], 32'hFFFFA5C3, va);
         chk_word("buffer", (i == 4) ? 32'h00000000 : 32'h0000A5C3, va);
      end
      wr(32'h44000050, 32'hFFFFFFFF);
      chk_reg("unmapped", 32'h44000050, 32'h00000000);
      wr(FPT_DIVDMA_ADDR, 32'hFFFFFFFF);
      chk_reg("divider select", FPT_DIVDMA_ADDR, 32'h00FFFFFF);
      wr(FPT_DIVDMA_ADDR, 32'h00000000);
      wr(FPT_CONTROL_ADDR, 32'hFF8000F4);
      chk_reg("control", FPT_CONTROL_ADDR, 32'h00000014);
      wr(FPT_CONTROL_ADDR, 32'h00000004);
      settle(3);
      chk_bit("inverted pin", 1'b0, pulse_output[0]);
      // channel 0 one-shot, prescaler 0 and divide by 2
      wr(FPT_CNTB_ADDR[0], 32'h00000003);
      wr(FPT_CMPB_ADDR[0], 32'h00000001);
      wr(FPT_CONTROL_ADDR, 32'h00000002);
      chk_reg("manual load", FPT_OBS_ADDR[0], 32'h00000003);
      settle(10);
      chk_bit("pin above compare", 1'b0, pulse_output[0]);
      chk_reg("halted counter", FPT_OBS_ADDR[0], 32'h00000003);
      wr(FPT_CONTROL_ADDR, 32'h00000001);
      wait_stat(0);
      settle(10);
      chk_reg("one-shot end", FPT_OBS_ADDR[0], 32'h00000000);
      chk_bit("pin at zero", 1'b1, pulse_output[0]);
      chk_bit("masked irq", 1'b0, irq);
      wr(FPT_MASK_ADDR, 32'h00000001);
      settle(2);
      chk_bit("unmasked irq", 1'b1, irq);
      wr(FPT_STATUS_ADDR, 32'h00000001);
      settle(2);
      chk_bit("cleared irq", 1'b0, irq);
      // channel 1 interval mode must fire twice
      wr(FPT_CNTB_ADDR[1], 32'h00000002);
      wr(FPT_CONTROL_ADDR, 32'h00000200);
      wr(FPT_CONTROL_ADDR, 32'h00000900);
      wait_stat(1);
      wr(FPT_STATUS_ADDR, 32'h00000002);
      wait_stat(1);
      wr(FPT_CONTROL_ADDR, 32'h00000000);
      // channel 4 loads only its counter
      wr(FPT_CNTB_ADDR[4], 32'h00000007);
      wr(FPT_CONTROL_ADDR, 32'h00200000);
      chk_reg("ch4 load", FPT_OBS_ADDR[4], 32'h00000007);
      wr(FPT_CONTROL_ADDR, 32'h00000000);
      // tick period is 3 * divider with prescaler 2; reads 192 cycles apart
      wr(FPT_PRESCALE_ADDR, 32'h00000002);
      for (int c = 0; c < 4; c++)
      begin
         wr(FPT_DIVDMA_ADDR, fpt_word_t'(c));
         wr(FPT_CNTB_ADDR[0], 32'h00001000);
         wr(FPT_CONTROL_ADDR, 32'h00000002);
         wr(FPT_CONTROL_ADDR, 32'h00000009);
         settle(20);
         rd(FPT_OBS_ADDR[0], va);
         repeat (190) @(posedge clk_sys);
         rd(FPT_OBS_ADDR[0], vb);
         chk_word("divider ticks", fpt_word_t'(192 / (3 * (2 << c))), va - vb);
         wr(FPT_CONTROL_ADDR, 32'h00000000);
      end
      wr(FPT_PRESCALE_ADDR, 32'h00000000);
      wr(FPT_DIVDMA_ADDR, 32'h00100000);
      wr(FPT_STATUS_ADDR, 32'h0000001F);
      dma_round(4'h0);
      dma_round(4'h6);
      // reserved dma code falls back to interrupts
      wr(FPT_DIVDMA_ADDR, 32'h00600000);
      wr(FPT_CONTROL_ADDR, 32'h00000002);
      wr(FPT_CONTROL_ADDR, 32'h00000001);
      wait_stat(0);
      settle(2);
      chk_bit("no dma request", 1'b1, dma_request_n);
      chk_bit("reserved code irq", 1'b1, irq);
      close_out();
   end
endmodule

// >>> verification/fpt_dma_model.sv
`timescale 1ns/100ps
module fpt_dma_model
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // handshake
   input  wire logic       dma_request_n,
   output logic            dma_ack,
   // pacing
   input  wire logic [3:0] ack_delay
);
   logic [3:0] wait_q = 4'h0;
   logic       ack_q  = 1'b0;

   assign dma_ack = ack_q;

   // one-cycle acknowledge; a slow delay shows whether the request is held meanwhile
   always_ff @(posedge clk_sys)
   begin
      if (reset || ack_q)
      begin
         ack_q  <= 1'b0;
         wait_q <= 4'h0;
      end
      else if (!dma_request_n)
      begin
         if (wait_q >= ack_delay)
            ack_q <= 1'b1;
         else
            wait_q <= wait_q + 4'h1;
      end
   end
endmodule
